// ===== cmd_params.svh
// Constants for the console microstate display multiplexer
`ifndef CMD_PARAMS_SVH
`define CMD_PARAMS_SVH
`define CMD_UADDR_W 8
`define CMD_LAMP_W 16
`define CMD_HI_LSB 8
`define CMD_TS_W 2
`define CMD_TS1 2'h0
`define CMD_TS2 2'h1
`define CMD_TS3 2'h2
`define CMD_TS4 2'h3
`define CMD_FST_0 8'h7b
`define CMD_FST_1 8'h89
`define CMD_FST_2 8'hf2
`define CMD_FST_3 8'hce
`define CMD_FST_4 8'hfe
`define CMD_FST_5 8'hfd
`define CMD_FST_6 8'h1e
`define CMD_FST_7 8'h95
`define CMD_DSEL_W 2
`define CMD_DSEL_UADDR 2'h3
`define CMD_ASEL_W 3
`define CMD_ASEL_CONSOLE_PHYSICAL_VIEW 3'h6
`define CMD_ASEL_PROGRAM_PHYSICAL_VIEW 3'h7
`endif

// ===== cmd_pkg.sv
// Types for the console microstate display multiplexer
`include "cmd_params.svh"
package cmd_pkg;
  typedef enum logic [1:0] {
    CMD_STEP_RUN,
    CMD_STEP_CLOCK,
    CMD_STEP_ROM,
    CMD_STEP_MATCH
  } cmd_step_e;

  typedef struct packed {
    logic [`CMD_UADDR_W-1:0] fpu_cur;
    logic [`CMD_UADDR_W-1:0] fpu_next;
    logic [`CMD_UADDR_W-1:0] cpu_cur;
    logic [`CMD_UADDR_W-1:0] cpu_next;
  } cmd_uaddr_s;

  typedef struct packed {
    logic [`CMD_LAMP_W-1:0] data;
    logic [`CMD_LAMP_W-1:0] addr;
    logic data_uaddr;
    logic addr_exponent_alu;
  } cmd_lamps_s;
endpackage : cmd_pkg

// ===== cmd_sync.sv
// Two-stage synchroniser for console switch levels
`timescale 1ns/1ns
module cmd_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  initial
  begin
    if (WIDTH < 1)
    begin
      $error("cmd_sync width must be positive");
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= '0;
      q <= '0;
    end
    else if (ce)
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : cmd_sync

// ===== cmd_display_mux.sv
// Console lamp multiplexer for microcode addresses and exponent ALU
`timescale 1ns/1ns
`include "cmd_params.svh"
// Notes on behaviour
// [R1] Data lamps: coprocessor high byte, CPU low
// [R2] Operator selects microaddress view on data switch
// [R3] Single clock: current in TS1-2, next after
// [R4] ROM step or match shows next coprocessor address
// [R5] Coprocessor address updates at end of TS2
// [R6] Exponent ALU drives address lamps 15-0
// [R7] Exponent ALU shown only in eight float states
// [R8] Operator sets address switch to physical views
// [R9] Operator single-steps both units for meaning
// [R10] Other selector positions show normal sources
module cmd_display_mux (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [`CMD_TS_W-1:0] time_state,
  input wire logic ts2_end,
  input wire cmd_pkg::cmd_step_e step_mode,
  input wire cmd_pkg::cmd_uaddr_s uaddr,
  input wire logic [`CMD_LAMP_W-1:0] exponent_alu,
  input wire logic [`CMD_LAMP_W-1:0] normal_data,
  input wire logic [`CMD_LAMP_W-1:0] normal_addr,
  input wire logic [`CMD_DSEL_W-1:0] data_sel_sw,
  input wire logic [`CMD_ASEL_W-1:0] addr_sel_sw,
  output cmd_pkg::cmd_lamps_s lamps
);
  logic [`CMD_DSEL_W-1:0] data_sel;
  logic [`CMD_ASEL_W-1:0] addr_sel;
  logic [`CMD_UADDR_W-1:0] fpu_shown_reg;
  logic [`CMD_UADDR_W-1:0] fpu_show;
  logic [`CMD_UADDR_W-1:0] cpu_show;
  logic late_half;
  logic show_uaddr;
  logic show_exponent_alu;
  logic [`CMD_LAMP_W-1:0] data_lamp_reg;
  logic [`CMD_LAMP_W-1:0] addr_lamp_reg;
  logic data_uaddr_reg;
  logic addr_exponent_alu_reg;

  // Switches come from the operator panel, outside the clock domain
  cmd_sync #(.WIDTH(`CMD_DSEL_W)) u_dsel_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .d(data_sel_sw),
    .q(data_sel)
  );

  cmd_sync #(.WIDTH(`CMD_ASEL_W)) u_asel_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .d(addr_sel_sw),
    .q(addr_sel)
  );

  function automatic logic is_float_state(input logic [`CMD_UADDR_W-1:0] a);
    case (a)
      `CMD_FST_0, `CMD_FST_1, `CMD_FST_2, `CMD_FST_3,
      `CMD_FST_4, `CMD_FST_5, `CMD_FST_6, `CMD_FST_7: is_float_state = 1'b1; // [R7]
      default: is_float_state = 1'b0;
    endcase
  endfunction : is_float_state

  // Coprocessor address register loads at end of TS2; a pause after TS2
  // holds it because ts2_end only pulses once per microcycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fpu_shown_reg <= '0;
    end
    else if (ce && ts2_end)
    begin
      fpu_shown_reg <= uaddr.fpu_next; // [R5]
    end
  end

  assign late_half = (time_state == `CMD_TS3) || (time_state == `CMD_TS4);

  always_comb
  begin
    fpu_show = uaddr.fpu_cur;
    cpu_show = uaddr.cpu_cur;
    case (step_mode)
      cmd_pkg::CMD_STEP_CLOCK:
      begin
        fpu_show = late_half ? fpu_shown_reg : uaddr.fpu_cur; // [R3]
        cpu_show = late_half ? uaddr.cpu_next : uaddr.cpu_cur; // [R3]
      end
      cmd_pkg::CMD_STEP_ROM, cmd_pkg::CMD_STEP_MATCH:
      begin
        fpu_show = uaddr.fpu_next; // [R4]
      end
      default:
      begin
        fpu_show = uaddr.fpu_cur;
        cpu_show = uaddr.cpu_cur;
      end
    endcase
  end

  assign show_uaddr = (data_sel == `CMD_DSEL_UADDR); // [R2]
  assign show_exponent_alu = ((addr_sel == `CMD_ASEL_CONSOLE_PHYSICAL_VIEW) ||
                      (addr_sel == `CMD_ASEL_PROGRAM_PHYSICAL_VIEW)) && // [R8]
                     is_float_state(uaddr.cpu_cur); // [R7]

  // Lamps are registered so the panel never sees decode glitches
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_lamp_reg <= '0;
      data_uaddr_reg <= 1'b0;
    end
    else if (ce)
    begin
      data_uaddr_reg <= show_uaddr;
      if (show_uaddr)
      begin
        data_lamp_reg <= {fpu_show, cpu_show}; // [R1]
      end
      else
      begin
        data_lamp_reg <= normal_data; // [R10]
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addr_lamp_reg <= '0;
      addr_exponent_alu_reg <= 1'b0;
    end
    else if (ce)
    begin
      addr_exponent_alu_reg <= show_exponent_alu;
      if (show_exponent_alu)
      begin
        addr_lamp_reg <= exponent_alu; // [R6]
      end
      else
      begin
        addr_lamp_reg <= normal_addr; // [R10]
      end
    end
  end

  // One driver for the whole bundle keeps each field single-sourced
  assign lamps = {data_lamp_reg, addr_lamp_reg, data_uaddr_reg, addr_exponent_alu_reg};

  property p_data_uaddr;
    @(posedge clk) disable iff (!rst_n)
    (ce && show_uaddr && step_mode == cmd_pkg::CMD_STEP_RUN) |=>
      lamps.data == {$past(uaddr.fpu_cur), $past(uaddr.cpu_cur)};
  endproperty
  a_data_uaddr: assert property (p_data_uaddr) // [R1]
    else $error("Data lamps do not show paired microaddresses");

  property p_clock_late;
    @(posedge clk) disable iff (!rst_n)
    (ce && show_uaddr && step_mode == cmd_pkg::CMD_STEP_CLOCK && late_half) |=>
      lamps.data[`CMD_HI_LSB-1:0] == $past(uaddr.cpu_next);
  endproperty
  a_clock_late: assert property (p_clock_late) // [R3]
    else $error("Late time states must show next address");

  property p_clock_early;
    @(posedge clk) disable iff (!rst_n)
    (ce && show_uaddr && step_mode == cmd_pkg::CMD_STEP_CLOCK && !late_half) |=>
      lamps.data[`CMD_HI_LSB-1:0] == $past(uaddr.cpu_cur);
  endproperty
  a_clock_early: assert property (p_clock_early) // [R3]
    else $error("Early time states must show current address");

  property p_rom_next;
    @(posedge clk) disable iff (!rst_n)
    (ce && show_uaddr && step_mode == cmd_pkg::CMD_STEP_ROM) |=>
      lamps.data[`CMD_LAMP_W-1:`CMD_HI_LSB] == $past(uaddr.fpu_next);
  endproperty
  a_rom_next: assert property (p_rom_next) // [R4]
    else $error("ROM stepping must show next coprocessor address");

  property p_fpu_load;
    @(posedge clk) disable iff (!rst_n)
    (ce && ts2_end) |=> fpu_shown_reg == $past(uaddr.fpu_next);
  endproperty
  a_fpu_load: assert property (p_fpu_load) // [R5]
    else $error("Coprocessor address not loaded at end of TS2");

  property p_fpu_hold;
    @(posedge clk) disable iff (!rst_n)
    (!ts2_end) |=> $stable(fpu_shown_reg);
  endproperty
  a_fpu_hold: assert property (p_fpu_hold) // [R5]
    else $error("Coprocessor address changed outside TS2 end");

  property p_exponent_alu_shown;
    @(posedge clk) disable iff (!rst_n)
    (ce && show_exponent_alu) |=> lamps.addr == $past(exponent_alu) && lamps.addr_exponent_alu;
  endproperty
  a_exponent_alu_shown: assert property (p_exponent_alu_shown) // [R6]
    else $error("Exponent ALU not on address lamps");

  property p_exponent_alu_only_float;
    @(posedge clk) disable iff (!rst_n)
    (ce && !is_float_state(uaddr.cpu_cur)) |=> !lamps.addr_exponent_alu;
  endproperty
  a_exponent_alu_only_float: assert property (p_exponent_alu_only_float) // [R7]
    else $error("Exponent ALU shown outside float states");

  property p_normal;
    @(posedge clk) disable iff (!rst_n)
    (ce && !show_uaddr && !show_exponent_alu) |=>
      lamps.data == $past(normal_data) && lamps.addr == $past(normal_addr);
  endproperty
  a_normal: assert property (p_normal) // [R10]
    else $error("Normal sources not shown");
endmodule : cmd_display_mux

// ===== cmd_console_model.sv
// Operator console model: selector switches facing the lamp multiplexer
`timescale 1ns/1ns
module cmd_console_model (
  input wire logic clk,
  input wire cmd_pkg::cmd_lamps_s lamps,
  output logic [1:0] data_sel_sw,
  output logic [2:0] addr_sel_sw
);
  initial
  begin
    data_sel_sw = 2'h0;
    addr_sel_sw = 3'h0;
  end
  // Returns only once the synchroniser and output stage have caught up
  task automatic turn(input logic [1:0] d, input logic [2:0] a);
    @(posedge clk);
    data_sel_sw <= d;
    addr_sel_sw <= a;
    repeat (4) @(posedge clk);
    #1;
  endtask : turn
endmodule : cmd_console_model

// ===== cmd_display_mux_tb.sv
// Self-checking bench for the console display multiplexer
`timescale 1ns/1ns
module cmd_display_mux_tb;
  logic clk, rst_n, ce, ts2_end;
  logic [1:0] time_state;
  cmd_pkg::cmd_step_e step_mode;
  cmd_pkg::cmd_uaddr_s uaddr;
  logic [15:0] exponent_alu, normal_data, normal_addr;
  logic [1:0] data_sel_sw;
  logic [2:0] addr_sel_sw;
  cmd_pkg::cmd_lamps_s lamps;
  logic [7:0] fst [8] = '{8'h7b, 8'h89, 8'hf2, 8'hce, 8'hfe, 8'hfd, 8'h1e, 8'h95};
  logic [7:0] held;
  int errors, checked;
  cmd_display_mux dut_u (.clk(clk), .rst_n(rst_n), .ce(ce), .time_state(time_state),
    .ts2_end(ts2_end), .step_mode(step_mode), .uaddr(uaddr), .exponent_alu(exponent_alu),
    .normal_data(normal_data), .normal_addr(normal_addr), .data_sel_sw(data_sel_sw),
    .addr_sel_sw(addr_sel_sw), .lamps(lamps));
  cmd_console_model con_u (.clk(clk), .lamps(lamps), .data_sel_sw(data_sel_sw),
    .addr_sel_sw(addr_sel_sw));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic drive(input cmd_pkg::cmd_step_e m, input logic [1:0] ts);
    @(posedge clk);
    step_mode <= m;
    time_state <= ts;
    repeat (2) @(posedge clk);
    #1;
  endtask : drive
  task automatic t_clock;
    drive(cmd_pkg::CMD_STEP_CLOCK, 2'h1);
    chk(lamps.data, {uaddr.fpu_cur, uaddr.cpu_cur});
    held = uaddr.fpu_next;
    @(posedge clk);
    ts2_end <= 1'b1;
    @(posedge clk);
    ts2_end <= 1'b0;
    uaddr.fpu_next <= 8'h9a;
    // Stepping both units one clock at a time, so the pause sits after the load
    drive(cmd_pkg::CMD_STEP_CLOCK, 2'h2);
    chk(lamps.data, {held, uaddr.cpu_next});
    drive(cmd_pkg::CMD_STEP_CLOCK, 2'h3);
    chk(lamps.data, {held, uaddr.cpu_next});
    drive(cmd_pkg::CMD_STEP_CLOCK, 2'h0);
    chk(lamps.data, {uaddr.fpu_cur, uaddr.cpu_cur});
  endtask : t_clock
  task automatic t_exponent_alu(input logic [2:0] a);
    con_u.turn(2'h3, a);
    for (int i = 0; i < 9; i++)
    begin
      @(posedge clk);
      uaddr.cpu_cur <= (i < 8) ? fst[i] : 8'h7c;
      exponent_alu <= {8'h5a, 8'(i)};
      repeat (2) @(posedge clk);
      #1;
      chk(lamps.addr, (i < 8) ? exponent_alu : normal_addr);
      chk({15'h0, lamps.addr_exponent_alu}, {15'h0, i < 8});
    end
  endtask : t_exponent_alu
  // Clock enable low must hold the lamps although the sources move
  task automatic t_freeze;
    @(posedge clk);
    ce <= 1'b0;
    uaddr.cpu_cur <= 8'h11;
    repeat (2) @(posedge clk);
    #1;
    chk(lamps.data, {uaddr.fpu_next, 8'h56});
    @(posedge clk);
    ce <= 1'b1;
    uaddr.cpu_cur <= 8'h56;
    repeat (2) @(posedge clk);
    #1;
    chk(lamps.data, {uaddr.fpu_next, uaddr.cpu_cur});
  endtask : t_freeze
  task automatic end_of_test;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test
  initial
  begin
    #200000;
    errors++;
    end_of_test();
  end
  initial
  begin
    rst_n = 1'b0;
    ts2_end = 1'b0;
    time_state = 2'h0;
    step_mode = cmd_pkg::CMD_STEP_RUN;
    ce = 1'b1;
    uaddr = {8'h12, 8'h34, 8'h56, 8'h78};
    exponent_alu = 16'ha5c3;
    normal_data = 16'h0f0f;
    normal_addr = 16'hf00f;
    repeat (12) @(posedge clk);
    chk(lamps.data, 16'h0);
    chk(lamps.addr, 16'h0);
    rst_n <= 1'b1;
    con_u.turn(2'h3, 3'h0);
    drive(cmd_pkg::CMD_STEP_RUN, 2'h0);
    chk(lamps.data, {uaddr.fpu_cur, uaddr.cpu_cur});
    chk({15'h0, lamps.data_uaddr}, 16'h1);
    t_clock();
    drive(cmd_pkg::CMD_STEP_ROM, 2'h2);
    chk(lamps.data, {uaddr.fpu_next, uaddr.cpu_cur});
    drive(cmd_pkg::CMD_STEP_MATCH, 2'h0);
    chk(lamps.data, {uaddr.fpu_next, uaddr.cpu_cur});
    t_freeze();
    t_exponent_alu(3'h6);
    t_exponent_alu(3'h7);
    @(posedge clk);
    uaddr.cpu_cur <= 8'h7b;
    con_u.turn(2'h0, 3'h5);
    chk(lamps.data, normal_data);
    chk(lamps.addr, normal_addr);
    chk({14'h0, lamps.data_uaddr, lamps.addr_exponent_alu}, 16'h0);
    end_of_test();
  end
endmodule : cmd_display_mux_tb
